// >>> rtl/tpc_pkg.sv
// Package: register map, field layout and prescale decode for the timer pair
package tpc_pkg;
   // Register offsets on the plain register port
   localparam logic [1:0] TPC_OFF_CTRL = 2'h0;
   localparam logic [1:0] TPC_OFF_CNT_LO = 2'h1;
   localparam logic [1:0] TPC_OFF_CNT_HI = 2'h2;
   // Control field positions
   localparam int TPC_BIT_RUN = 15;
   localparam int TPC_BIT_HALT = 13;
   localparam int TPC_BIT_GATE = 6;
   localparam int TPC_BIT_PS_HI = 5;
   localparam int TPC_BIT_PS_LO = 4;
   localparam int TPC_BIT_WIDE = 3;
   localparam int TPC_BIT_SRC = 1;
   // Reset values
   localparam logic TPC_RST_BIT = 1'b0;
   localparam logic [1:0] TPC_RST_PS = 2'h0;
   localparam logic [15:0] TPC_RST_HALF = 16'h0000;
   // Prescale select codes
   localparam logic [1:0] TPC_PS_1 = 2'h0;
   localparam logic [1:0] TPC_PS_8 = 2'h1;
   localparam logic [1:0] TPC_PS_64 = 2'h2;
   localparam logic [1:0] TPC_PS_256 = 2'h3;
   // Last prescaler count before a tick, per ratio
   localparam logic [7:0] TPC_MAX_1 = 8'h00;
   localparam logic [7:0] TPC_MAX_8 = 8'h07;
   localparam logic [7:0] TPC_MAX_64 = 8'h3F;
   localparam logic [7:0] TPC_MAX_256 = 8'hFF;

   // Prescale select to terminal count
   function automatic logic [7:0] tpc_ratio_max(input logic [1:0] sel);
      case (sel)
         TPC_PS_8: tpc_ratio_max = TPC_MAX_8;
         TPC_PS_64: tpc_ratio_max = TPC_MAX_64;
         TPC_PS_256: tpc_ratio_max = TPC_MAX_256;
         default: tpc_ratio_max = TPC_MAX_1;
      endcase
   endfunction
endpackage

// >>> rtl/tpc_pin_edge.sv
// Rising-edge and level capture of the external count or gate pin
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_edge (
   input wire logic mclk, // Clock
   input wire logic nrst, // Sync reset, active low
   input wire logic pin, // External count input
   output logic rise, // One-cycle pulse per rising edge
   output logic level // Pin level, one cycle late
);
   import tpc_pkg::*;
   typedef struct packed {
      logic prev;
      logic rise;
   } tpc_edge_st_t;
   tpc_edge_st_t st_ff;
   tpc_edge_st_t nxt_st;

   // Rise is judged against the stored level, so one edge gives one pulse
   always_comb begin
      nxt_st = st_ff;
      nxt_st.prev = pin;
      nxt_st.rise = pin & ~st_ff.prev;
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rise = st_ff.rise;
   assign level = st_ff.prev;

   // One rising edge never yields two pulses
   a_rise_single: assert property (@(posedge mclk) disable iff (!nrst)
      rise |=> !rise) else $error("edge pulse lasted two cycles");
endmodule // tpc_pin_edge
`default_nettype wire

// >>> rtl/tpc_prescale.sv
// Input prescaler: one tick per 1, 8, 64 or 256 steps
`timescale 1ns/1ps
`default_nettype none
module tpc_prescale (
   input wire logic mclk, // Clock
   input wire logic nrst, // Sync reset, active low
   input wire logic clr, // Restart the division
   input wire logic step, // One input clock event
   input wire logic [1:0] sel, // Prescale select
   output logic tick // One-cycle prescaled tick
);
   import tpc_pkg::*;
   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } tpc_ps_st_t;
   tpc_ps_st_t st_ff;
   tpc_ps_st_t nxt_st;

   // Count steps; wrap and tick at the selected terminal count
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (clr) begin
         nxt_st.cnt = 8'h00;
      end else if (step) begin
         if (st_ff.cnt >= tpc_ratio_max(sel)) begin
            nxt_st.cnt = 8'h00;
            nxt_st.tick = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick;

   // A tick comes only from a step taken at the terminal count
   a_tick_ratio: assert property (@(posedge mclk) disable iff (!nrst)
      tick |-> $past(step) && !$past(clr)
         && $past(st_ff.cnt) == tpc_ratio_max($past(sel)))
      else $error("prescaler ticked off its ratio");
endmodule // tpc_prescale
`default_nettype wire

// >>> rtl/tpc_timer.sv
// Top of the pairable timer: control register, clock source, counter
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tpc_timer #(
   parameter int HALF_W = 16 // Width of each timer half
) (
   input wire logic mclk, // Clock, 200 MHz
   input wire logic nrst, // Sync reset, active low
   input wire logic [1:0] addr, // Register address
   input wire logic [15:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [15:0] rdata, // Read data, cycle after rd
   input wire logic external_count_input, // Count or gate pin
   input wire logic idle_mode, // Chip is in idle
   output logic [2*HALF_W-1:0] count_value // Live counter
);
   import tpc_pkg::*;

   // The register port is 16 bits wide, so each half must match it
   if (HALF_W != 16) begin : g_bad_width
      $error("tpc_timer: HALF_W must be 16");
   end

   typedef struct packed {
      logic run;
      logic halt_in_idle;
      logic gate_accumulate_enable;
      logic [1:0] input_prescale_select;
      logic pair_wide_mode;
      logic count_source_select;
      logic half;
      logic [2*HALF_W-1:0] cnt;
      logic [15:0] rdata;
   } tpc_top_st_t;

   tpc_top_st_t st_ff;
   tpc_top_st_t nxt_st;

   logic ext_rise;
   logic ext_level;
   logic pre_tick;
   logic running;
   logic gate_on;
   logic src_step;
   logic ctrl_wr;
   logic [15:0] ctrl_view;

   // One strobe aimed at one register offset
   function automatic logic reg_hit(input logic strobe,
      input logic [1:0] a, input logic [1:0] off);
      reg_hit = strobe && (a == off);
   endfunction

   // Edge and level of the pin, shared by counting and gating
   tpc_pin_edge u_edge (
      .mclk(mclk),
      .nrst(nrst),
      .pin(external_count_input),
      .rise(ext_rise),
      .level(ext_level)
   );

   // Prescaler restarts on any control write so a new ratio starts clean
   tpc_prescale u_pre (
      .mclk(mclk),
      .nrst(nrst),
      .clr(ctrl_wr),
      .step(src_step),
      .sel(st_ff.input_prescale_select),
      .tick(pre_tick)
   );

   // Source selection and gating
   always_comb begin
      ctrl_wr = reg_hit(wr, addr, TPC_OFF_CTRL);
      running = st_ff.run && !(st_ff.halt_in_idle && idle_mode);
      gate_on = st_ff.gate_accumulate_enable
         && !st_ff.count_source_select;
      if (st_ff.count_source_select) begin
         src_step = running && ext_rise;
      end else begin
         // Gated: internal clocks pass only while the pin is high
         src_step = running && st_ff.half
            && (!gate_on || ext_level);
      end
   end

   // Control word as software sees it; unused positions are constant zero
   always_comb begin
      ctrl_view = 16'h0000;
      ctrl_view[TPC_BIT_RUN] = st_ff.run;
      ctrl_view[TPC_BIT_HALT] = st_ff.halt_in_idle;
      ctrl_view[TPC_BIT_GATE] = st_ff.gate_accumulate_enable;
      ctrl_view[TPC_BIT_PS_HI:TPC_BIT_PS_LO] = st_ff.input_prescale_select;
      ctrl_view[TPC_BIT_WIDE] = st_ff.pair_wide_mode;
      ctrl_view[TPC_BIT_SRC] = st_ff.count_source_select;
   end

   // Next state: register port, internal divider and counter
   always_comb begin
      nxt_st = st_ff;
      // Internal clock is mclk over two: toggle every cycle while running
      nxt_st.half = running ? !st_ff.half : 1'b0;
      if (ctrl_wr) begin
         nxt_st.run = wdata[TPC_BIT_RUN];
         nxt_st.halt_in_idle = wdata[TPC_BIT_HALT];
         nxt_st.gate_accumulate_enable = wdata[TPC_BIT_GATE];
         nxt_st.input_prescale_select =
            wdata[TPC_BIT_PS_HI:TPC_BIT_PS_LO];
         nxt_st.pair_wide_mode = wdata[TPC_BIT_WIDE];
         nxt_st.count_source_select = wdata[TPC_BIT_SRC];
      end
      // A software load beats a count in the same cycle
      if (reg_hit(wr, addr, TPC_OFF_CNT_LO)) begin
         nxt_st.cnt[HALF_W-1:0] = wdata;
      end else if (reg_hit(wr, addr, TPC_OFF_CNT_HI)) begin
         nxt_st.cnt[2*HALF_W-1:HALF_W] = wdata;
      end else if (pre_tick && running) begin
         if (st_ff.pair_wide_mode) begin
            nxt_st.cnt = st_ff.cnt + {{(2*HALF_W-1){1'b0}}, 1'b1};
         end else begin
            // Low half wraps alone; the partner half is left untouched
            nxt_st.cnt[HALF_W-1:0] = st_ff.cnt[HALF_W-1:0]
               + {{(HALF_W-1){1'b0}}, 1'b1};
         end
      end
      // Read data stand one cycle, unmapped reads give zero
      nxt_st.rdata = 16'h0000;
      if (rd) begin
         case (addr)
            TPC_OFF_CTRL: nxt_st.rdata = ctrl_view;
            TPC_OFF_CNT_LO: nxt_st.rdata = st_ff.cnt[HALF_W-1:0];
            TPC_OFF_CNT_HI: nxt_st.rdata = st_ff.cnt[2*HALF_W-1:HALF_W];
            default: nxt_st.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_ff.run <= TPC_RST_BIT;
         st_ff.halt_in_idle <= TPC_RST_BIT;
         st_ff.gate_accumulate_enable <= TPC_RST_BIT;
         st_ff.input_prescale_select <= TPC_RST_PS;
         st_ff.pair_wide_mode <= TPC_RST_BIT;
         st_ff.count_source_select <= TPC_RST_BIT;
         st_ff.half <= TPC_RST_BIT;
         st_ff.cnt <= {TPC_RST_HALF, TPC_RST_HALF};
         st_ff.rdata <= 16'h0000;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata = st_ff.rdata;
   assign count_value = st_ff.cnt;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_ctrl_zero_bits: assert property (
      rd && addr == TPC_OFF_CTRL |=> rdata[12:7] == 6'h00
         && !rdata[2] && !rdata[0] && !rdata[14])
      else $error("unused control bits read nonzero");

   a_gate_ignored: assert property (
      st_ff.count_source_select |-> src_step == (running && ext_rise))
      else $error("gate affected external counting");

   a_gate_blocks: assert property (
      !st_ff.count_source_select && st_ff.gate_accumulate_enable
         && !ext_level |-> !src_step)
      else $error("gated count ran with gate low");

   a_gate_passes: assert property (
      running && !st_ff.count_source_select
         && st_ff.gate_accumulate_enable && ext_level && st_ff.half
         |-> src_step)
      else $error("gated count missed a clock while gate high");

   a_internal_half: assert property (
      running && !st_ff.count_source_select
         && !st_ff.gate_accumulate_enable
         |-> src_step == st_ff.half ##1 st_ff.half == !$past(st_ff.half))
      else $error("internal clock is not mclk over two");

   a_ext_edge: assert property (
      running && st_ff.count_source_select && ext_rise |-> src_step)
      else $error("external edge not counted");

   a_idle_halt: assert property (
      st_ff.halt_in_idle && idle_mode && !wr |=> $stable(count_value))
      else $error("timer moved while halted in idle");

   a_wide_carry: assert property (
      pre_tick && running && !wr && st_ff.pair_wide_mode
         && st_ff.cnt[HALF_W-1:0] == 16'hFFFF
         |=> count_value[2*HALF_W-1:HALF_W]
            == $past(st_ff.cnt[2*HALF_W-1:HALF_W]) + 16'h0001)
      else $error("32-bit mode lost the carry");

   a_split_halves: assert property (
      pre_tick && running && !wr && !st_ff.pair_wide_mode
         |=> $stable(count_value[2*HALF_W-1:HALF_W]))
      else $error("16-bit mode touched the partner half");

   // Register writes land in the fields they name
   a_run_lands: assert property (
      ctrl_wr |=> st_ff.run == $past(wdata[TPC_BIT_RUN]))
      else $error("run bit did not take the write");

   a_halt_lands: assert property (
      ctrl_wr |=> st_ff.halt_in_idle == $past(wdata[TPC_BIT_HALT]))
      else $error("halt bit did not take the write");

   a_gate_lands: assert property (
      ctrl_wr
         |=> st_ff.gate_accumulate_enable == $past(wdata[TPC_BIT_GATE]))
      else $error("gate bit did not take the write");

   a_ps_lands: assert property (
      ctrl_wr |=> st_ff.input_prescale_select
         == $past(wdata[TPC_BIT_PS_HI:TPC_BIT_PS_LO]))
      else $error("prescale field did not take the write");

   a_wide_lands: assert property (
      ctrl_wr |=> st_ff.pair_wide_mode == $past(wdata[TPC_BIT_WIDE]))
      else $error("pair mode bit did not take the write");

   a_src_lands: assert property (
      ctrl_wr |=> st_ff.count_source_select == $past(wdata[TPC_BIT_SRC]))
      else $error("source bit did not take the write");

   // Read data stand one cycle only, zero otherwise
   a_rdata_idle: assert property (
      !rd |=> rdata == 16'h0000)
      else $error("read data stood without a read");

   // A new ratio starts from a cleared prescaler
   a_ps_restart: assert property (
      ctrl_wr |=> !pre_tick)
      else $error("prescaler ticked right after a control write");

   // Each tick adds exactly one to the low half
   a_low_step: assert property (
      pre_tick && running && !wr
         |=> count_value[HALF_W-1:0] == $past(count_value[HALF_W-1:0])
            + 16'h0001)
      else $error("low half did not step by one");

   // Without a tick or a load the count holds
   a_no_tick_hold: assert property (
      !pre_tick && !wr |=> $stable(count_value))
      else $error("count moved without a tick");

   // Pair mode: the upper half moves only on a carry
   a_wide_hold: assert property (
      pre_tick && running && !wr && st_ff.pair_wide_mode
         && st_ff.cnt[HALF_W-1:0] != 16'hFFFF
         |=> $stable(count_value[2*HALF_W-1:HALF_W]))
      else $error("upper half moved without a carry");

   // External source: steps come from pin edges alone
   a_ext_only_edges: assert property (
      st_ff.count_source_select && !ext_rise |-> !src_step)
      else $error("external source stepped without an edge");

   // Internal steps are never back to back
   a_internal_gap: assert property (
      !st_ff.count_source_select && src_step && !ctrl_wr |=> !src_step)
      else $error("internal clock stepped twice in a row");

   // The divide-by-two phase restarts whenever counting stops
   a_half_restart: assert property (
      !running |=> !st_ff.half)
      else $error("internal divider kept its phase while stopped");

   // Ungated internal counting ignores the pin
   a_ungated_steps: assert property (
      running && !st_ff.count_source_select
         && !st_ff.gate_accumulate_enable && st_ff.half |-> src_step)
      else $error("ungated internal clock was held back");

   // Stopped or halted: the count holds
   a_stopped_hold: assert property (
      !running && !wr |=> $stable(count_value))
      else $error("count moved while stopped");

   // Halt off: idle does not stop the timer
   a_idle_runs: assert property (
      st_ff.run && !st_ff.halt_in_idle |-> running)
      else $error("timer stopped in idle with halt off");
endmodule // tpc_timer
`default_nettype wire

// >>> bench/tpc_pin_model.sv
// Far-side model of the external count or gate pin
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_model (
   input wire logic mclk, // Clock shared with the timer
   output logic pin // External count input
);
   // Pin idles low between bursts
   initial begin
      pin = 1'b0;
   end

   // Rising edges, each one cycle high then at least one low
   task automatic pulses(input int n, input int gap);
      repeat (n) begin
         @(posedge mclk) pin <= 1'b1;
         @(posedge mclk) pin <= 1'b0;
         repeat (gap) @(posedge mclk);
      end
   endtask

   // Steady level, used as the gate
   task automatic hold(input logic v);
      @(posedge mclk) pin <= v;
   endtask
endmodule // tpc_pin_model
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the pairable timer control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tpc_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic idle_mode = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic [15:0] r;
   logic [31:0] count_value;
   logic [31:0] c0;
   logic pin;
   int n_errors = 0;
   int num_checks = 0;
   int ratio [4] = '{1, 8, 64, 256};

   tpc_timer DUT (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .external_count_input(pin),
      .idle_mode(idle_mode), .count_value(count_value));
   tpc_pin_model PM (.mclk(mclk), .pin(pin));

   always #2.5 mclk = ~mclk;

   task automatic conclude();
      if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle bus strobes, changed just after the edge
   task automatic wreg(input logic [1:0] a, input logic [15:0] d);
      @(posedge mclk) begin
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
      end
      @(posedge mclk) wr <= 1'b0;
   endtask

   task automatic rreg(input logic [1:0] a, output logic [15:0] d);
      @(posedge mclk) begin
         addr <= a;
         rd <= 1'b1;
      end
      @(posedge mclk) rd <= 1'b0;
      #1 d = rdata; // Data stand only in this cycle
   endtask

   // Stop, preload the count, then start with the given control
   task automatic setup(input logic [15:0] ctl, input logic [15:0] lo);
      wreg(TPC_OFF_CTRL, 16'h0000);
      wreg(TPC_OFF_CNT_LO, lo);
      wreg(TPC_OFF_CNT_HI, 16'h0000);
      wreg(TPC_OFF_CTRL, ctl);
   endtask

   task automatic t_reserved();
      wreg(TPC_OFF_CTRL, 16'hFFFF);
      rreg(TPC_OFF_CTRL, r);
      chk(r, 16'hA07A);
      wreg(2'h3, 16'h1234);
      rreg(2'h3, r);
      chk(r, 16'h0000);
   endtask

   // Internal clock: exactly k increments per 2*N*k mclk cycles
   task automatic t_prescale();
      for (int s = 0; s < 4; s++) begin
         setup(16'h8000 | 16'(s << 4), 16'h0000);
         repeat (20) @(posedge mclk);
         #1 c0 = count_value;
         repeat (2 * ratio[s] * 3) @(posedge mclk);
         #1 chk(count_value - c0, 32'd3);
      end
   endtask

   // External edges count, gate bit set but ignored
   task automatic t_external();
      setup(16'h8042, 16'h0000);
      PM.pulses(5, 2);
      repeat (6) @(posedge mclk);
      chk(count_value, 32'd5);
      setup(16'h8052, 16'h0000);
      PM.pulses(16, 1);
      repeat (6) @(posedge mclk);
      chk(count_value, 32'd2);
   endtask

   task automatic t_gated();
      setup(16'h8040, 16'h0000);
      repeat (50) @(posedge mclk);
      chk(count_value, 32'd0);
      PM.hold(1'b1);
      repeat (40) @(posedge mclk);
      PM.hold(1'b0);
      repeat (10) @(posedge mclk);
      chk(32'(count_value >= 18 && count_value <= 22), 32'd1);
      c0 = count_value;
      repeat (30) @(posedge mclk);
      chk(count_value, c0);
   endtask

   task automatic t_wide();
      setup(16'h8008, 16'hFFFE);
      repeat (20) @(posedge mclk);
      chk(32'(count_value[31:16]), 32'd1);
      setup(16'h8000, 16'hFFFE);
      repeat (20) @(posedge mclk);
      chk(32'(count_value[31:16]), 32'd0);
      chk(32'(count_value[15:0] < 16'h0010), 32'd1);
   endtask

   // Idle freezes only with halt set
   task automatic t_idle();
      idle_mode <= 1'b1;
      setup(16'hA000, 16'h0000);
      repeat (40) @(posedge mclk);
      chk(count_value, 32'd0);
      setup(16'h8000, 16'h0000);
      repeat (40) @(posedge mclk);
      chk(32'(count_value > 32'd10), 32'd1);
      idle_mode <= 1'b0;
   endtask

   // Reset in mid-run clears the count and stops the timer
   task automatic t_reset();
      setup(16'hA07A, 16'h1234);
      repeat (10) @(posedge mclk);
      chk(count_value, 32'h00001234);
      nrst <= 1'b0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      rreg(TPC_OFF_CTRL, r);
      chk(r, 16'h0000);
      chk(count_value, 32'h00000000);
      repeat (10) @(posedge mclk);
      chk(count_value, 32'h00000000);
   endtask

   // Bounded run; running out counts as a mismatch
   initial begin
      repeat (100000) @(posedge mclk);
      n_errors++;
      $display("Error at %0t: run did not finish", $time);
      conclude();
   end

   initial begin
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      rreg(TPC_OFF_CTRL, r);
      chk(r, 16'h0000);
      chk(count_value, 32'd0);
      t_reserved();
      t_prescale();
      t_external();
      t_gated();
      t_wide();
      t_idle();
      t_reset();
      conclude();
   end
endmodule // tb_top
`default_nettype wire
